// ==== fat_pkg.sv ====
// Constants, field layout and types for the flow monitor
package fat_pkg;

  // Timing: one-second tick and second-based intervals
  localparam int CLK_PERIOD_NS = 100;
  localparam int SECOND_NS     = 1_000_000_000;
  localparam int TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
  localparam int BANNER_S      = 2;
  localparam int ALT_S         = 2;
  localparam int WARMUP_MIN    = 6;
  localparam int WARMUP_S      = WARMUP_MIN * 60;
  localparam int SEC_PER_MIN   = 60;

  // Limits
  localparam int UNIT_MAX   = 22;
  localparam int GAS_TABLES = 10;
  localparam int DELAY_MAX  = 3600;

  // Register offsets
  localparam logic [7:0] REG_UNIT   = 8'h00;
  localparam logic [7:0] REG_GAS    = 8'h04;
  localparam logic [7:0] REG_TCTRL  = 8'h08;
  localparam logic [7:0] REG_TSTART = 8'h0c;
  localparam logic [7:0] REG_TSTOP  = 8'h10;
  localparam logic [7:0] REG_TOTAL  = 8'h14;
  localparam logic [7:0] REG_ACTRL  = 8'h18;
  localparam logic [7:0] REG_ALOW   = 8'h1c;
  localparam logic [7:0] REG_AHIGH  = 8'h20;
  localparam logic [7:0] REG_ADELAY = 8'h24;
  localparam logic [7:0] REG_RELAY  = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2c;

  // Field positions
  localparam int TUNIT_LSB  = 8;
  localparam int UNCAL_BIT  = 8;
  localparam int TEN_BIT    = 0;
  localparam int TCLR_BIT   = 1;
  localparam int AEN_BIT    = 0;
  localparam int LATCH_LSB  = 1;
  localparam int RLY_STRIDE = 4;

  // Reset values
  localparam logic [4:0]  UNIT_RST  = 5'h00;
  localparam logic [3:0]  GAS_RST   = 4'h0;
  localparam logic [15:0] LOW_RST   = 16'h0000;
  localparam logic [15:0] HIGH_RST  = 16'h03e8;
  localparam logic [11:0] DELAY_RST = 12'h000;

  typedef enum logic [1:0] {SCR_BANNER1, SCR_BANNER2, SCR_MAIN} fat_screen_e;
  typedef enum logic [2:0] {
    ASG_NONE, ASG_TOTAL, ASG_HIGH, ASG_LOW, ASG_RANGE, ASG_MANUAL
  } fat_asg_e;
  typedef enum logic [3:0] {
    TU_PCT_S, TU_ML, TU_LTR, TU_M3, TU_FT3, TU_G, TU_KG, TU_LB, TU_USER
  } fat_tunit_e;

  // Totalizer unit paired with a rate unit code
  function automatic fat_tunit_e fat_tunit_of(input logic [4:0] u);
    int q;
    q = (int'(u) + 2) / 3;
    if (u == 5'(UNIT_MAX)) return TU_USER;
    return fat_tunit_e'(4'(q));
  endfunction

endpackage

// ==== fat_monitor.sv ====
// Flow alarm, totalizer, warm-up and display sequencing monitor
//
// Contract
// - Banner one, banner two, two seconds each, then main
// - Main screen: rate unit, total and unit
// - Amber status light during six-minute warm-up
// - Green status light after warm-up ends
// - Diagnostic warm-up countdown alternates every two seconds
// - Rate unit codes 0..22, readable and writable
// - Rate unit change switches paired totalizer unit
// - Ten gas tables, read and select
// - Uncalibrated table reported as uncalibrated
// - Totalizer clear, start, stop, enable, read
// - No accumulation below start threshold
// - Stop value zero disables stop action
// - Action true when total equals stop
// - Disabled alarm raises no conditions
// - Below low or above high is alarm
// - Alarm after condition persists for delay
// - Two-bit latch mode, one bit per relay
// - Assigned relays energize on their condition
// - Unlatched alarm shown only while condition holds
// - All alarm settings and status readable
// - Six relay assignments incl. manual
`timescale 1ns/10ps
`default_nettype none

module fat_monitor
  import fat_pkg::*;
#(
  parameter int FLOW_W   = 16,
  parameter int TOT_W    = 32,
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RESETN,
  input  wire logic              I_CE,
  input  wire logic [7:0]        I_ADDR,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [31:0]       O_RDATA,
  input  wire logic [FLOW_W-1:0] I_FLOW_PCT,
  input  wire logic [FLOW_W-1:0] I_FLOW_RATE,
  input  wire logic [9:0]        I_GAS_VALID,
  input  wire logic              I_BUTTON,
  input  wire logic              I_DIAG_EN,
  output var fat_screen_e        O_SCREEN,
  output logic [4:0]             O_RATE_UNIT,
  output var fat_tunit_e         O_TOT_UNIT,
  output logic [TOT_W-1:0]       O_TOTAL,
  output logic [3:0]             O_GAS_TABLE,
  output logic                   O_GAS_UNCAL,
  output logic                   O_LINE2_WARM,
  output logic [2:0]             O_WARM_MIN,
  output logic [5:0]             O_WARM_SEC,
  output logic                   O_LED_AMBER,
  output logic                   O_LED_GREEN,
  output logic                   O_ALARM_LO,
  output logic                   O_ALARM_HI,
  output logic                   O_TOT_REACHED,
  output logic [1:0]             O_RELAY
);

  logic [$clog2(TICK_CYC)-1:0] tick_cnt;
  logic                        tick;
  logic [1:0]                  bn_cnt;
  logic [1:0]                  alt_cnt;
  logic                        alt_phase;
  logic [8:0]                  warm_left;
  logic                        tot_en;
  logic [FLOW_W-1:0]           tot_start;
  logic [TOT_W-1:0]            tot_stop;
  logic                        alm_en;
  logic [1:0]                  latch_mode;
  logic [FLOW_W-1:0]           alm_low;
  logic [FLOW_W-1:0]           alm_high;
  logic [11:0]                 alm_delay;
  fat_asg_e                    rly_asg [2];
  logic                        rly_latch [2];
  logic [11:0]                 alm_cnt [2];
  logic [1:0]                  raw;
  logic [1:0]                  ind;
  logic [1:0]                  rly_cond;
  logic                        in_range;
  logic                        wr_unit;
  logic                        tot_clr;
  logic                        tot_hit;

  // One-second tick from the system clock
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (I_CE) begin
      tick <= (tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1));
      if (tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end

  // Power-up banner sequence
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_SCREEN <= SCR_BANNER1;
      bn_cnt   <= 2'h0;
    end else if (I_CE && tick && O_SCREEN != SCR_MAIN) begin
      if (bn_cnt == 2'(BANNER_S - 1)) begin
        bn_cnt <= 2'h0;
        case (O_SCREEN)
          SCR_BANNER1: O_SCREEN <= SCR_BANNER2;
          SCR_BANNER2: O_SCREEN <= SCR_MAIN;
          default:     O_SCREEN <= SCR_MAIN;
        endcase
      end else begin
        bn_cnt <= bn_cnt + 1'b1;
      end
    end
  end

  // Warm-up countdown, status light and line-two alternation
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      warm_left    <= 9'(WARMUP_S);
      alt_cnt      <= 2'h0;
      alt_phase    <= 1'b0;
      O_LED_AMBER  <= 1'b1;
      O_LED_GREEN  <= 1'b0;
      O_LINE2_WARM <= 1'b0;
      O_WARM_MIN   <= 3'h0;
      O_WARM_SEC   <= 6'h00;
    end else if (I_CE) begin
      if (tick && warm_left != 9'h000) begin
        warm_left <= warm_left - 1'b1;
      end
      if (tick) begin
        alt_cnt <= (alt_cnt == 2'(ALT_S - 1)) ? 2'h0 : alt_cnt + 1'b1;
        if (alt_cnt == 2'(ALT_S - 1)) begin
          alt_phase <= ~alt_phase;
        end
      end
      O_LED_AMBER  <= (warm_left != 9'h000);
      O_LED_GREEN  <= (warm_left == 9'h000);
      O_LINE2_WARM <= I_DIAG_EN && warm_left != 9'h000 && !alt_phase;
      O_WARM_MIN   <= 3'(warm_left / 9'(SEC_PER_MIN));
      O_WARM_SEC   <= 6'(warm_left % 9'(SEC_PER_MIN));
    end
  end

  // Unit and gas table settings
  assign wr_unit = I_WR && I_ADDR == REG_UNIT && I_WDATA[4:0] <= 5'(UNIT_MAX);

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_RATE_UNIT <= UNIT_RST;
      O_TOT_UNIT  <= fat_tunit_of(UNIT_RST);
      O_GAS_TABLE <= GAS_RST;
      O_GAS_UNCAL <= 1'b0;
    end else if (I_CE) begin
      if (wr_unit) begin
        O_RATE_UNIT <= I_WDATA[4:0];
        O_TOT_UNIT  <= fat_tunit_of(I_WDATA[4:0]);
      end
      if (I_WR && I_ADDR == REG_GAS && I_WDATA[3:0] < 4'(GAS_TABLES)) begin
        O_GAS_TABLE <= I_WDATA[3:0];
      end
      O_GAS_UNCAL <= !I_GAS_VALID[O_GAS_TABLE];
    end
  end

  // Totalizer settings
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      tot_en    <= 1'b0;
      tot_start <= '0;
      tot_stop  <= '0;
    end else if (I_CE && I_WR) begin
      case (I_ADDR)
        REG_TCTRL:  tot_en    <= I_WDATA[TEN_BIT];
        REG_TSTART: tot_start <= I_WDATA[FLOW_W-1:0];
        REG_TSTOP:  tot_stop  <= I_WDATA[TOT_W-1:0];
        default:    tot_en    <= tot_en;
      endcase
    end
  end

  // Clear by command, or by button held during power-up screens
  assign tot_clr = (I_WR && I_ADDR == REG_TCTRL && I_WDATA[TCLR_BIT])
                 || (I_BUTTON && O_SCREEN != SCR_MAIN);
  assign tot_hit = tot_stop != '0 && O_TOTAL == tot_stop;

  // Accumulation once per second at or above the start threshold
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_TOTAL       <= '0;
      O_TOT_REACHED <= 1'b0;
    end else if (I_CE) begin
      if (tot_clr) begin
        O_TOTAL <= '0;
      end else if (tick && tot_en && I_FLOW_PCT >= tot_start) begin
        O_TOTAL <= O_TOTAL + TOT_W'(I_FLOW_RATE);
      end
      if (tot_hit) begin
        O_TOT_REACHED <= 1'b1;
      end else if (tot_clr) begin
        O_TOT_REACHED <= 1'b0;
      end
    end
  end

  // Alarm settings
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      alm_en     <= 1'b0;
      latch_mode <= 2'h0;
      alm_low    <= FLOW_W'(LOW_RST);
      alm_high   <= FLOW_W'(HIGH_RST);
      alm_delay  <= DELAY_RST;
      rly_asg[0] <= ASG_NONE;
      rly_asg[1] <= ASG_NONE;
    end else if (I_CE && I_WR) begin
      case (I_ADDR)
        REG_ACTRL: begin
          alm_en     <= I_WDATA[AEN_BIT];
          latch_mode <= I_WDATA[LATCH_LSB+1:LATCH_LSB];
        end
        REG_ALOW:  alm_low  <= I_WDATA[FLOW_W-1:0];
        REG_AHIGH: alm_high <= I_WDATA[FLOW_W-1:0];
        REG_ADELAY: begin
          if (I_WDATA[11:0] <= 12'(DELAY_MAX) && I_WDATA[31:12] == 20'h00000) begin
            alm_delay <= I_WDATA[11:0];
          end
        end
        REG_RELAY: begin
          rly_asg[0] <= fat_asg_e'(I_WDATA[2:0]);
          rly_asg[1] <= fat_asg_e'(I_WDATA[RLY_STRIDE+2:RLY_STRIDE]);
        end
        default: alm_en <= alm_en;
      endcase
    end
  end

  // Raw limit conditions, index 0 low and 1 high
  assign raw[0]   = alm_en && I_FLOW_PCT < alm_low;
  assign raw[1]   = alm_en && I_FLOW_PCT > alm_high;
  assign in_range = alm_en && !raw[0] && !raw[1];

  // Persistence counter per alarm condition
  for (genvar k = 0; k < 2; k++) begin : g_alm
    assign ind[k] = raw[k] && alm_cnt[k] >= alm_delay;
    always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
        alm_cnt[k] <= 12'h000;
      end else if (I_CE) begin
        if (!raw[k]) begin
          alm_cnt[k] <= 12'h000;
        end else if (tick && alm_cnt[k] < alm_delay) begin
          alm_cnt[k] <= alm_cnt[k] + 1'b1;
        end
      end
    end
  end

  // Alarm indications
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_ALARM_LO <= 1'b0;
      O_ALARM_HI <= 1'b0;
    end else if (I_CE) begin
      O_ALARM_LO <= ind[0];
      O_ALARM_HI <= ind[1];
    end
  end

  // Relay drive with optional latch per relay
  for (genvar r = 0; r < 2; r++) begin : g_rly
    always_comb begin
      case (rly_asg[r])
        ASG_TOTAL:  rly_cond[r] = O_TOT_REACHED;
        ASG_HIGH:   rly_cond[r] = ind[1];
        ASG_LOW:    rly_cond[r] = ind[0];
        ASG_RANGE:  rly_cond[r] = in_range;
        ASG_MANUAL: rly_cond[r] = 1'b1;
        default:    rly_cond[r] = 1'b0;
      endcase
    end
    always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
        rly_latch[r] <= 1'b0;
        O_RELAY[r]   <= 1'b0;
      end else if (I_CE) begin
        if (!alm_en || !latch_mode[r]) begin
          rly_latch[r] <= 1'b0;
        end else if (rly_cond[r] && rly_asg[r] inside {ASG_HIGH, ASG_LOW, ASG_RANGE}) begin
          rly_latch[r] <= 1'b1;
        end
        O_RELAY[r] <= rly_cond[r] || (rly_latch[r] && alm_en && latch_mode[r]);
      end
    end
  end

  // Register read port, data valid only the cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      O_RDATA <= 32'h00000000;
    end else if (I_CE) begin
      O_RDATA <= 32'h00000000;
      if (I_RD) begin
        case (I_ADDR)
          REG_UNIT:   O_RDATA <= {20'h0, O_TOT_UNIT, 3'h0, O_RATE_UNIT};
          REG_GAS:    O_RDATA <= {23'h0, O_GAS_UNCAL, 4'h0, O_GAS_TABLE};
          REG_TCTRL:  O_RDATA <= {31'h0, tot_en};
          REG_TSTART: O_RDATA <= 32'(tot_start);
          REG_TSTOP:  O_RDATA <= 32'(tot_stop);
          REG_TOTAL:  O_RDATA <= 32'(O_TOTAL);
          REG_ACTRL:  O_RDATA <= {29'h0, latch_mode, alm_en};
          REG_ALOW:   O_RDATA <= 32'(alm_low);
          REG_AHIGH:  O_RDATA <= 32'(alm_high);
          REG_ADELAY: O_RDATA <= {20'h0, alm_delay};
          REG_RELAY:  O_RDATA <= {25'h0, rly_asg[1], 1'b0, rly_asg[0]};
          REG_STATUS: O_RDATA <= {24'h0, raw, O_RELAY, O_TOT_REACHED,
                                  O_ALARM_HI, O_ALARM_LO, O_LED_GREEN};
          default:    O_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  property p_led_excl;
    O_LED_AMBER != O_LED_GREEN;
  endproperty
  a_led_excl: assert property (p_led_excl) else $error("status light colours overlap");

  property p_amber;
    (I_CE && warm_left != 9'h000) |=> O_LED_AMBER && !O_LED_GREEN;
  endproperty
  a_amber: assert property (p_amber) else $error("amber missing in warm-up");

  property p_green;
    (I_CE && warm_left == 9'h000) |=> O_LED_GREEN ##1 (!I_CE || O_LED_GREEN);
  endproperty
  a_green: assert property (p_green) else $error("green missing after warm-up");

  property p_unit_pair;
    (I_CE && wr_unit) |=> O_TOT_UNIT == fat_tunit_of($past(I_WDATA[4:0]));
  endproperty
  a_unit_pair: assert property (p_unit_pair) else $error("totalizer unit not paired");

  property p_below_start;
    (I_CE && !tot_clr && I_FLOW_PCT < tot_start) |=> O_TOTAL == $past(O_TOTAL);
  endproperty
  a_below_start: assert property (p_below_start) else $error("accumulated below start");

  property p_hit;
    (I_CE && tot_stop != '0 && O_TOTAL == tot_stop) |=> O_TOT_REACHED;
  endproperty
  a_hit: assert property (p_hit) else $error("stop total not flagged");

  property p_disabled;
    (I_CE && !alm_en) |=> !O_ALARM_HI && !O_ALARM_LO;
  endproperty
  a_disabled: assert property (p_disabled) else $error("alarm while disabled");

  property p_delay;
    (I_CE && O_ALARM_HI) |-> $past(alm_cnt[1]) >= $past(alm_delay) && $past(raw[1]);
  endproperty
  a_delay: assert property (p_delay) else $error("alarm before delay elapsed");

  property p_manual;
    (I_CE && rly_asg[0] == ASG_MANUAL) |=> O_RELAY[0];
  endproperty
  a_manual: assert property (p_manual) else $error("manual relay not energized");

  property p_unlatched;
    (I_CE && !latch_mode[0] && rly_asg[0] == ASG_HIGH && !ind[1]) |=> !O_RELAY[0];
  endproperty
  a_unlatched: assert property (p_unlatched) else $error("unlatched relay held");

  c_hi_alarm: cover property (I_CE && O_ALARM_HI);
  c_latched:  cover property (I_CE && rly_latch[0] && !ind[1] && O_RELAY[0]);
  c_reached:  cover property (I_CE && O_TOT_REACHED);
  c_warm_end: cover property (I_CE && O_LED_GREEN && O_SCREEN == SCR_MAIN);

endmodule

`default_nettype wire

// ==== fat_host.sv ====
// Host computer model driving the monitor's register port
`timescale 1ns/10ps
`default_nettype none

module fat_host
  import fat_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [31:0] i_rdata,
  output logic      [7:0]  o_addr,
  output logic      [31:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  // Idle bus at time zero
  initial begin
    o_addr  = 8'h00;
    o_wdata = 32'h0000_0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask

  // Limits go out only when low sits below high
  task automatic set_limits(input logic [15:0] lo, input logic [15:0] hi);
    if (lo < hi) begin
      wr(REG_ALOW, {16'h0000, lo});
      wr(REG_AHIGH, {16'h0000, hi});
    end
  endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench for the flow monitor
`timescale 1ns/10ps
`default_nettype none

module tb import fat_pkg::*; ;
  localparam int TK = 10;

  logic        clk, ce, rstn, button, diag, wr, rd, uncal, l2, amber, green, alo, ahi, reached;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, total;
  logic [15:0] pct;
  logic [9:0]  valid;
  logic [4:0]  unit;
  logic [3:0]  gas;
  logic [2:0]  wmin;
  logic [5:0]  wsec;
  logic [1:0]  relay;
  fat_screen_e screen;
  fat_tunit_e  tunit;
  int          cyc, fail_count, n_compared;

  fat_monitor #(.TICK_CYC(TK)) dut (
    .I_CLK(clk), .I_RESETN(rstn), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_FLOW_PCT(pct), .I_FLOW_RATE(16'h0007),
    .I_GAS_VALID(valid), .I_BUTTON(button), .I_DIAG_EN(diag), .O_SCREEN(screen),
    .O_RATE_UNIT(unit), .O_TOT_UNIT(tunit), .O_TOTAL(total), .O_GAS_TABLE(gas),
    .O_GAS_UNCAL(uncal), .O_LINE2_WARM(l2), .O_WARM_MIN(wmin), .O_WARM_SEC(wsec),
    .O_LED_AMBER(amber), .O_LED_GREEN(green), .O_ALARM_LO(alo), .O_ALARM_HI(ahi),
    .O_TOT_REACHED(reached), .O_RELAY(relay)
  );

  fat_host h (
    .i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
  );

  // Clock at 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cycles since reset release
  always @(posedge clk) begin
    if (!rstn) cyc <= 0;
    else cyc <= cyc + 1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic upto(input int n);
    while (cyc < n) @(posedge clk);
    #1;
  endtask

  // Park four cycles after a tick boundary
  task automatic align;
    while (cyc % TK != 4) step(1);
  endtask

  task automatic setp(input logic [15:0] v);
    @(posedge clk);
    pct <= v;
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict;
  end

  // Main sequence
  initial begin
    logic [31:0] d;
    fail_count = 0;
    n_compared = 0;
    rstn = 1'b0;
    button = 1'b1;
    diag = 1'b1;
    ce = 1'b1;
    pct = 16'd150;
    valid = 10'h005;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // Power-up banners, warm-up light and countdown
    upto(2);
    chk("amber0", 1, amber);
    chk("green0", 0, green);
    chk("scr0", SCR_BANNER1, 32'(screen));
    chk("min0", 6, wmin);
    chk("sec0", 0, wsec);
    @(posedge clk);
    button <= 1'b0;
    upto(15);
    chk("scr15", SCR_BANNER1, 32'(screen));
    chk("l2_15", 1, l2);
    chk("min15", 5, wmin);
    chk("sec15", 59, wsec);
    upto(30);
    chk("scr30", SCR_BANNER2, 32'(screen));
    chk("l2_30", 0, l2);
    upto(50);
    chk("scr50", SCR_MAIN, 32'(screen));
    chk("l2_50", 1, l2);
    // Every rate unit and its paired total unit
    for (int u = 0; u <= 22; u++) begin
      h.wr(REG_UNIT, 32'(u));
      step(1);
      chk("unit", 32'(u), 32'(unit));
      chk("tunit", 32'(u == 0 ? 0 : (u == 22 ? 8 : (u - 1) / 3 + 1)), 32'(tunit));
    end
    h.wr(REG_UNIT, 32'd23);
    h.rd(REG_UNIT, d);
    chk("unit_rd", 32'h0000_0816, d);
    // Every gas table, tables 0 and 2 calibrated
    for (int t = 0; t < 10; t++) begin
      h.wr(REG_GAS, 32'(t));
      step(2);
      chk("gas", 32'(t), 32'(gas));
      chk("uncal", 32'(!valid[t]), 32'(uncal));
    end
    h.wr(REG_GAS, 32'd10);
    h.rd(REG_GAS, d);
    chk("gas_rd", 32'h0000_0109, d);
    // Totalizer start gate and stop flag
    setp(16'd40);
    h.wr(REG_TSTART, 32'd50);
    h.wr(REG_TSTOP, 32'd14);
    h.wr(REG_TCTRL, 32'h3);
    step(35);
    chk("tot_below", 0, total);
    align();
    setp(16'd50);
    step(10);
    chk("tot_one", 32'd7, total);
    step(10);
    chk("tot_two", 32'd14, total);
    chk("reached", 1, reached);
    h.wr(REG_TSTOP, 32'd0);
    align();
    h.wr(REG_TCTRL, 32'h3);
    step(18);
    chk("tot_nostop", 32'd14, total);
    chk("no_reach", 0, reached);
    h.wr(REG_TCTRL, 32'h0);
    step(20);
    h.rd(REG_TOTAL, d);
    chk("tot_held", 32'd14, d);
    // Alarms: relay one on high, relay two on low
    h.wr(REG_RELAY, 32'h32);
    h.set_limits(16'd100, 16'd200);
    h.wr(REG_ADELAY, 32'd3);
    h.wr(REG_ACTRL, 32'h1);
    setp(16'd250);
    step(15);
    chk("hi_early", 0, ahi);
    step(30);
    chk("hi", 1, ahi);
    chk("relay_hi", 32'h1, relay);
    setp(16'd150);
    step(3);
    chk("hi_gone", 0, ahi);
    chk("relay_off", 0, relay);
    h.wr(REG_ACTRL, 32'h3);
    setp(16'd250);
    step(45);
    setp(16'd150);
    step(3);
    chk("latched", 32'h1, relay);
    h.wr(REG_ACTRL, 32'h0);
    step(3);
    chk("unlatch", 0, relay);
    setp(16'd50);
    step(45);
    chk("lo_off", 0, alo);
    h.wr(REG_ACTRL, 32'h1);
    step(45);
    chk("lo", 1, alo);
    chk("relay_lo", 32'h2, relay);
    h.rd(REG_STATUS, d);
    chk("status", 32'h0000_0062, d);
    h.rd(REG_ALOW, d);
    chk("alow", 32'd100, d);
    h.wr(REG_RELAY, 32'h45);
    setp(16'd150);
    step(3);
    chk("manual_range", 32'h3, relay);
    // End of warm-up
    upto(3590);
    chk("amber_end", 1, amber);
    upto(3615);
    chk("green", 1, green);
    chk("amber_off", 0, amber);
    chk("l2_done", 0, l2);
    // Clock enable low freezes the tick and the total
    align();
    h.wr(REG_TCTRL, 32'h1);
    @(posedge clk);
    ce <= 1'b0;
    step(30);
    chk("tot_frozen", 32'd14, total);
    @(posedge clk);
    ce <= 1'b1;
    step(10);
    chk("tot_resume", 32'd21, total);
    give_verdict;
  end
endmodule

`default_nettype wire
